// ===== rtl/port_power_pad_control.sv
// Pad control for port supply switch pads, status LED pull-up and port 1 source
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// [R1] LED pull-up bit 0 enables pad pull-up
// [R2] Pull-down bits 7:1 per supply pad
// [R3] Direction bits 7:1: 0 input, 1 output
// [R4] Output bits 7:1 hold driven pad data
// [R5] Input register read-only, sampled pad levels
// [R6] Pull-up bits 7:1 per pad, bit 0 read-only
// [R7] Port 1 bit 7 selects shared pins
// [R8] Port 1 bit 5 disables port while set; a later write of 0 re-enables it
// [R9] Port 1 bit 4 reports fixed attachment
// [R10] Port 1 field 3:0 picks power source
// [R11] Source settings loaded once, never changed live; the block does not lock them, so a later write still takes effect
// [R12] Flag bits programmed before hub enumerates
// [R13] Pad drives only while direction is output
module port_power_pad_control (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Register port
  input  wire logic [15:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [7:0]       reg_rdata,
  // Supply switch pads, bit 0 unused
  input  wire logic [7:0]  port_supply_switch_pad_i,
  output logic [7:0]       port_supply_switch_pad_o,
  output logic [7:0]       port_supply_switch_pad_oe,
  output logic [7:0]       supply_pad_pulldown_bits,
  output logic [7:0]       supply_pad_pullup_bits,
  // Status indicator pad
  output logic             status_indicator_pin_pullup,
  // Port 1 power sources and status
  input  wire logic        usb2_power,
  input  wire logic        usb3_power,
  input  wire logic        gpio_power,
  output logic             port1_power_on,
  output logic             port1_shared_pin,
  output logic             port1_disabled,
  output logic             fixed_attach_flag
);
  logic [7:0] led_pu_r, led_pu_nxt;
  logic [7:0] pd_r, pd_nxt;
  logic [7:0] dir_r, dir_nxt;
  logic [7:0] out_r, out_nxt;
  logic [7:0] in_r, in_nxt;
  logic [7:0] pu_r, pu_nxt;
  logic [7:0] sel1_r, sel1_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic       mux_power;

  // Masked write merge: read-only and reserved read-only bits keep old value
  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wd, input logic [7:0] msk);
    merge = (old & ~msk) | (wd & msk);
  endfunction

  // Register writes and input sampling
  always_comb begin
    led_pu_nxt = led_pu_r;
    pd_nxt     = pd_r;
    dir_nxt    = dir_r;
    out_nxt    = out_r;
    pu_nxt     = pu_r;
    sel1_nxt   = sel1_r;
    in_nxt     = port_supply_switch_pad_i & pad_ctrl_pkg::PAD_MASK; // [R5]
    if (reg_wr) begin
      case (reg_addr)
        pad_ctrl_pkg::LED_PU_OFS:  led_pu_nxt = merge(led_pu_r, reg_wdata, pad_ctrl_pkg::LED_PU_MASK); // [R1]
        // Reserved bit 0 kept writable, as printed
        pad_ctrl_pkg::PWR_PD_OFS:  pd_nxt  = reg_wdata; // [R2]
        pad_ctrl_pkg::PWR_DIR_OFS: dir_nxt = reg_wdata; // [R3]
        pad_ctrl_pkg::PWR_OUT_OFS: out_nxt = reg_wdata; // [R4]
        pad_ctrl_pkg::PWR_PU_OFS:  pu_nxt  = merge(pu_r, reg_wdata, pad_ctrl_pkg::PAD_MASK); // [R6]
        // Loaded by configuration; the block does not lock it
        pad_ctrl_pkg::SEL1_OFS:    sel1_nxt = merge(sel1_r, reg_wdata, pad_ctrl_pkg::SEL1_MASK); // [R11] [R12]
        default: ;
      endcase
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    rdata_nxt = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        pad_ctrl_pkg::LED_PU_OFS:  rdata_nxt = led_pu_r;
        pad_ctrl_pkg::PWR_PD_OFS:  rdata_nxt = pd_r;
        pad_ctrl_pkg::PWR_DIR_OFS: rdata_nxt = dir_r;
        pad_ctrl_pkg::PWR_OUT_OFS: rdata_nxt = out_r;
        pad_ctrl_pkg::PWR_IN_OFS:  rdata_nxt = in_r; // [R5]
        pad_ctrl_pkg::PWR_PU_OFS:  rdata_nxt = pu_r;
        pad_ctrl_pkg::SEL1_OFS:    rdata_nxt = sel1_r;
        default:                   rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      led_pu_r <= pad_ctrl_pkg::PAD_RST;
      pd_r     <= pad_ctrl_pkg::PAD_RST;
      dir_r    <= pad_ctrl_pkg::PAD_RST;
      out_r    <= pad_ctrl_pkg::PAD_RST;
      in_r     <= pad_ctrl_pkg::PAD_RST;
      pu_r     <= pad_ctrl_pkg::PAD_RST;
      sel1_r   <= pad_ctrl_pkg::SEL1_RST;
      rdata_r  <= 8'h00;
    end else begin
      led_pu_r <= led_pu_nxt;
      pd_r     <= pd_nxt;
      dir_r    <= dir_nxt;
      out_r    <= out_nxt;
      in_r     <= in_nxt;
      pu_r     <= pu_nxt;
      sel1_r   <= sel1_nxt;
      rdata_r  <= rdata_nxt;
    end
  end

  supply_source_mux u_mux (
    .supply_source_select (sel1_r[3:0]),
    .port_disabled        (sel1_r[pad_ctrl_pkg::DISABLE_BIT]),
    .usb2_power           (usb2_power),
    .usb3_power           (usb3_power),
    .gpio_power           (gpio_power),
    .power_on             (mux_power)
  );

  // Pad drive; bit 0 has no pad, so never enabled
  assign port_supply_switch_pad_o    = out_r & pad_ctrl_pkg::PAD_MASK; // [R4]
  assign port_supply_switch_pad_oe   = dir_r & pad_ctrl_pkg::PAD_MASK; // [R3] [R13]
  assign supply_pad_pulldown_bits    = pd_r & pad_ctrl_pkg::PAD_MASK; // [R2]
  assign supply_pad_pullup_bits      = pu_r & pad_ctrl_pkg::PAD_MASK; // [R6]
  assign status_indicator_pin_pullup = led_pu_r[pad_ctrl_pkg::LED_PU_BIT]; // [R1]
  assign reg_rdata                   = rdata_r;
  assign port1_power_on              = mux_power; // [R10]
  assign port1_shared_pin            = sel1_r[pad_ctrl_pkg::SHARED_BIT]; // [R7]
  assign port1_disabled              = sel1_r[pad_ctrl_pkg::DISABLE_BIT]; // [R8]
  assign fixed_attach_flag           = sel1_r[pad_ctrl_pkg::FIXED_BIT]; // [R9]

  // Address decode for the register port; anything else is a hole that reads zero
  function automatic logic is_mapped(input logic [15:0] a);
    case (a)
      pad_ctrl_pkg::LED_PU_OFS,
      pad_ctrl_pkg::PWR_PD_OFS,
      pad_ctrl_pkg::PWR_DIR_OFS,
      pad_ctrl_pkg::PWR_OUT_OFS,
      pad_ctrl_pkg::PWR_IN_OFS,
      pad_ctrl_pkg::PWR_PU_OFS,
      pad_ctrl_pkg::SEL1_OFS: is_mapped = 1'b1;
      default:                is_mapped = 1'b0;
    endcase
  endfunction

  // Write strobes per target; the sampled reset term keeps the release edge out
  sequence dir_wr_s;
    !sys_rst && reg_wr && reg_addr == pad_ctrl_pkg::PWR_DIR_OFS;
  endsequence
  sequence out_wr_s;
    !sys_rst && reg_wr && reg_addr == pad_ctrl_pkg::PWR_OUT_OFS;
  endsequence
  sequence pd_wr_s;
    !sys_rst && reg_wr && reg_addr == pad_ctrl_pkg::PWR_PD_OFS;
  endsequence
  sequence pu_wr_s;
    !sys_rst && reg_wr && reg_addr == pad_ctrl_pkg::PWR_PU_OFS;
  endsequence
  sequence sel_wr_s;
    !sys_rst && reg_wr && reg_addr == pad_ctrl_pkg::SEL1_OFS;
  endsequence

  // Read strobes per target; data follows one cycle later
  sequence led_rd_s;
    !sys_rst && reg_rd && reg_addr == pad_ctrl_pkg::LED_PU_OFS;
  endsequence
  sequence pd_rd_s;
    !sys_rst && reg_rd && reg_addr == pad_ctrl_pkg::PWR_PD_OFS;
  endsequence
  sequence dir_rd_s;
    !sys_rst && reg_rd && reg_addr == pad_ctrl_pkg::PWR_DIR_OFS;
  endsequence
  sequence out_rd_s;
    !sys_rst && reg_rd && reg_addr == pad_ctrl_pkg::PWR_OUT_OFS;
  endsequence
  sequence pu_rd_s;
    !sys_rst && reg_rd && reg_addr == pad_ctrl_pkg::PWR_PU_OFS;
  endsequence
  sequence sel_rd_s;
    !sys_rst && reg_rd && reg_addr == pad_ctrl_pkg::SEL1_OFS;
  endsequence

  // Write to direction makes pad drive next cycle
  dir_drive_a: assert property (@(posedge clk) disable iff (sys_rst) // [R3]
    dir_wr_s |=> port_supply_switch_pad_oe == ($past(reg_wdata) & pad_ctrl_pkg::PAD_MASK))
    else $error("direction write not reflected in enables");
  out_drive_a: assert property (@(posedge clk) disable iff (sys_rst) // [R4]
    out_wr_s |=> port_supply_switch_pad_o == ($past(reg_wdata) & pad_ctrl_pkg::PAD_MASK))
    else $error("output write not reflected on pads");
  pd_bits_a: assert property (@(posedge clk) disable iff (sys_rst) // [R2]
    pd_wr_s |=> supply_pad_pulldown_bits == ($past(reg_wdata) & pad_ctrl_pkg::PAD_MASK))
    else $error("pull-down write lost");
  pu_bits_a: assert property (@(posedge clk) disable iff (sys_rst) // [R6]
    pu_wr_s |=> supply_pad_pullup_bits == ($past(reg_wdata) & pad_ctrl_pkg::PAD_MASK))
    else $error("pull-up write lost");
  led_pu_a: assert property (@(posedge clk) disable iff (sys_rst) // [R1]
    (reg_wr && reg_addr == pad_ctrl_pkg::LED_PU_OFS) |=> status_indicator_pin_pullup == $past(reg_wdata[0]))
    else $error("led pull-up not following bit 0");
  in_read_a: assert property (@(posedge clk) disable iff (sys_rst) // [R5]
    (reg_rd && reg_addr == pad_ctrl_pkg::PWR_IN_OFS) ##0 $past(!sys_rst)
      |=> reg_rdata == ($past(port_supply_switch_pad_i, 2) & 8'hfe))
    else $error("input read does not show sampled pads");
  sel_flags_a: assert property (@(posedge clk) disable iff (sys_rst) // [R7] [R9]
    (reg_wr && reg_addr == pad_ctrl_pkg::SEL1_OFS) |=> port1_shared_pin == $past(reg_wdata[7])
      && fixed_attach_flag == $past(reg_wdata[4]))
    else $error("port 1 flags not updated");
  disabled_off_a: assert property (@(posedge clk) disable iff (sys_rst) // [R8]
    port1_disabled |-> !port1_power_on)
    else $error("disabled port powered");
  src_usb2_a: assert property (@(posedge clk) disable iff (sys_rst) // [R10]
    (sel1_r[5:0] == 6'h01) |-> port1_power_on == usb2_power)
    else $error("usb2 source not followed");
  src_either_a: assert property (@(posedge clk) disable iff (sys_rst) // [R10]
    (sel1_r[5:0] == 6'h03) |-> port1_power_on == (usb2_power | usb3_power))
    else $error("either source not followed");
  src_usb3_a: assert property (@(posedge clk) disable iff (sys_rst) // [R10]
    (sel1_r[5:0] == 6'h02) |-> port1_power_on == usb3_power)
    else $error("usb3 source not followed");
  src_gpio_a: assert property (@(posedge clk) disable iff (sys_rst) // [R10]
    (sel1_r[5:0] == 6'h04) |-> port1_power_on == gpio_power)
    else $error("gpio source not followed");
  // Off and reserved codes never power the port, whatever the sources do
  src_off_a: assert property (@(posedge clk) disable iff (sys_rst) // [R10]
    (sel1_r[3:0] == 4'h0) |-> !port1_power_on)
    else $error("port powered with source off");
  src_rsvd_a: assert property (@(posedge clk) disable iff (sys_rst) // [R10]
    (sel1_r[3:0] > 4'h4) |-> !port1_power_on)
    else $error("port powered by reserved code");
  dis_flag_a: assert property (@(posedge clk) disable iff (sys_rst) // [R8]
    sel_wr_s |=> port1_disabled == $past(reg_wdata[pad_ctrl_pkg::DISABLE_BIT]))
    else $error("disable flag not updated");

  // Input register tracks the pads one sample late and ignores writes
  in_sample_a: assert property (@(posedge clk) disable iff (sys_rst) // [R5]
    !sys_rst |=> in_r == ($past(port_supply_switch_pad_i) & pad_ctrl_pkg::PAD_MASK))
    else $error("input register not sampling pads");

  // Readback of each register except pull-up shows its stored value in the next cycle; pull-up readback only has bit 0 checked as zero
  rd_led_a: assert property (@(posedge clk) disable iff (sys_rst) // [R1]
    led_rd_s |=> reg_rdata == $past(led_pu_r))
    else $error("led pull-up readback wrong");
  rd_pd_a: assert property (@(posedge clk) disable iff (sys_rst) // [R2]
    pd_rd_s |=> reg_rdata == $past(pd_r))
    else $error("pull-down readback wrong");
  rd_dir_a: assert property (@(posedge clk) disable iff (sys_rst) // [R3]
    dir_rd_s |=> reg_rdata == $past(dir_r))
    else $error("direction readback wrong");
  rd_out_a: assert property (@(posedge clk) disable iff (sys_rst) // [R4]
    out_rd_s |=> reg_rdata == $past(out_r))
    else $error("output readback wrong");
  pu_bit0_a: assert property (@(posedge clk) disable iff (sys_rst) // [R6]
    pu_rd_s |=> !reg_rdata[0])
    else $error("pull-up bit 0 not read as zero");
  rd_sel_a: assert property (@(posedge clk) disable iff (sys_rst) // [R10]
    sel_rd_s |=> reg_rdata == $past(sel1_r) && !reg_rdata[6])
    else $error("port 1 select readback wrong");

  // Read data stands for one cycle only; holes read zero
  rd_hole_a: assert property (@(posedge clk) disable iff (sys_rst)
    (!sys_rst && reg_rd && !is_mapped(reg_addr)) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  rdata_idle_a: assert property (@(posedge clk) disable iff (sys_rst)
    (!sys_rst && !reg_rd) |=> reg_rdata == 8'h00)
    else $error("read data without a read strobe");

  // Configuration stands until its own register is written
  pd_hold_a: assert property (@(posedge clk) disable iff (sys_rst) // [R2]
    !sys_rst && !(reg_wr && reg_addr == pad_ctrl_pkg::PWR_PD_OFS) |=> $stable(supply_pad_pulldown_bits))
    else $error("pull-down bits changed without a write");
  dir_hold_a: assert property (@(posedge clk) disable iff (sys_rst) // [R3]
    !sys_rst && !(reg_wr && reg_addr == pad_ctrl_pkg::PWR_DIR_OFS) |=> $stable(port_supply_switch_pad_oe))
    else $error("pad enables changed without a write");
  out_hold_a: assert property (@(posedge clk) disable iff (sys_rst) // [R4]
    !sys_rst && !(reg_wr && reg_addr == pad_ctrl_pkg::PWR_OUT_OFS) |=> $stable(port_supply_switch_pad_o))
    else $error("pad data changed without a write");
  pu_hold_a: assert property (@(posedge clk) disable iff (sys_rst) // [R6]
    !sys_rst && !(reg_wr && reg_addr == pad_ctrl_pkg::PWR_PU_OFS) |=> $stable(supply_pad_pullup_bits))
    else $error("pull-up bits changed without a write");
  led_hold_a: assert property (@(posedge clk) disable iff (sys_rst) // [R1]
    !sys_rst && !(reg_wr && reg_addr == pad_ctrl_pkg::LED_PU_OFS) |=> $stable(status_indicator_pin_pullup))
    else $error("led pull-up changed without a write");
  // Source selection is never changed by the block itself
  sel_hold_a: assert property (@(posedge clk) disable iff (sys_rst) // [R10]
    !sys_rst && !(reg_wr && reg_addr == pad_ctrl_pkg::SEL1_OFS) |=> $stable(sel1_r))
    else $error("port 1 select changed without a write");
endmodule
`default_nettype wire

// ===== rtl/pad_ctrl_pkg.sv
// Constants and types shared by the port supply pad control block
package pad_ctrl_pkg;
  // Register offsets (byte addresses on the plain register port)
  localparam logic [15:0] LED_PU_OFS   = 16'h083f;
  localparam logic [15:0] PWR_PD_OFS   = 16'h092e;
  localparam logic [15:0] PWR_DIR_OFS  = 16'h0932;
  localparam logic [15:0] PWR_OUT_OFS  = 16'h0936;
  localparam logic [15:0] PWR_IN_OFS   = 16'h093a;
  localparam logic [15:0] PWR_PU_OFS   = 16'h093e;
  localparam logic [15:0] SEL1_OFS     = 16'h3c00;
  // Reset values
  localparam logic [7:0]  PAD_RST      = 8'h00;
  localparam logic [7:0]  SEL1_RST     = 8'h00;
  // Writable masks
  localparam logic [7:0]  LED_PU_MASK  = 8'hff;
  localparam logic [7:0]  PAD_MASK     = 8'hfe;
  localparam logic [7:0]  SEL1_MASK    = 8'hbf;
  // Field positions in the port 1 source register and the LED pull-up register
  localparam int          SHARED_BIT   = 7;
  localparam int          DISABLE_BIT  = 5;
  localparam int          FIXED_BIT    = 4;
  localparam int          LED_PU_BIT   = 0;
  // Source selection codes
  typedef enum logic [3:0] {
    SRC_OFF    = 4'h0,
    SRC_USB2   = 4'h1,
    SRC_USB3   = 4'h2,
    SRC_EITHER = 4'h3,
    SRC_GPIO   = 4'h4
  } supply_source_select_t;
endpackage

// ===== rtl/supply_source_mux.sv
// Port power source selection for one downstream port
`timescale 1ns/1ps
`default_nettype none
module supply_source_mux (
  // Selection
  input  wire logic [3:0] supply_source_select,
  input  wire logic       port_disabled,
  // Candidate sources
  input  wire logic       usb2_power,
  input  wire logic       usb3_power,
  input  wire logic       gpio_power,
  // Result
  output logic            power_on
);
  // Disabled ports never power up; reserved codes read as off
  always_comb begin
    power_on = 1'b0;
    case (supply_source_select)
      pad_ctrl_pkg::SRC_OFF:    power_on = 1'b0;
      pad_ctrl_pkg::SRC_USB2:   power_on = usb2_power; // [R10]
      pad_ctrl_pkg::SRC_USB3:   power_on = usb3_power; // [R10]
      pad_ctrl_pkg::SRC_EITHER: power_on = usb2_power | usb3_power; // [R10]
      pad_ctrl_pkg::SRC_GPIO:   power_on = gpio_power; // [R10]
      default:                  power_on = 1'b0;
    endcase
    if (port_disabled) begin
      power_on = 1'b0; // [R8]
    end
  end
endmodule
`default_nettype wire

// ===== bench/supply_switch_model.sv
// External supply switch and pad wire model
`timescale 1ns/1ps
`default_nettype none
module supply_switch_model (
  // Clock
  input  wire logic       clk,
  // Pad controls from the block
  input  wire logic [7:0] pad_o,
  input  wire logic [7:0] pad_oe,
  input  wire logic [7:0] pu,
  input  wire logic [7:0] pd,
  // External switch drive
  input  wire logic [7:0] ext_drv,
  input  wire logic [7:0] ext_en,
  // Resolved pad level
  output logic [7:0]      pad_i
);
  logic [7:0] flt_r = 8'h55;
  // Undriven pads wander so a stale level is never trusted
  always @(posedge clk) flt_r <= ~flt_r;
  // Block driver wins, then switch, then resistors
  always_comb begin
    for (int n = 0; n < 8; n++) begin
      if (pad_oe[n]) pad_i[n] = pad_o[n];
      else if (ext_en[n]) pad_i[n] = ext_drv[n];
      else if (pu[n]) pad_i[n] = 1'b1;
      else if (pd[n]) pad_i[n] = 1'b0;
      else pad_i[n] = flt_r[n];
    end
  end
endmodule
`default_nettype wire

// ===== bench/port_power_pad_control_tb.sv
// Self-checking bench for the supply pad control block
`timescale 1ns/1ps
`default_nettype none
module port_power_pad_control_tb;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  rdata, pad_i, pad_o, pad_oe, pd, pu;
  logic [7:0]  ext_drv = 8'ha0;
  logic [7:0]  ext_en = 8'hf0;
  logic [2:0]  src = 3'h0;
  logic        led_pu, pwr_on, shared, dis, fixed;
  int          miscompares = 0;
  int          n_tests = 0;
  typedef struct {logic [15:0] a; logic [7:0] w; logic [7:0] r;} row_t;
  // Address, write value, expected readback
  row_t rows[7] = '{
    '{pad_ctrl_pkg::LED_PU_OFS, 8'hff, 8'hff},
    '{pad_ctrl_pkg::PWR_PD_OFS, 8'hff, 8'hff},
    '{pad_ctrl_pkg::PWR_DIR_OFS, 8'h06, 8'h06},
    '{pad_ctrl_pkg::PWR_OUT_OFS, 8'h03, 8'h03},
    '{pad_ctrl_pkg::PWR_PU_OFS, 8'hff, 8'hfe},
    '{pad_ctrl_pkg::SEL1_OFS, 8'hff, 8'hbf},
    '{16'h0940, 8'hff, 8'h00}};
  always #5 clk = ~clk;
  port_power_pad_control i_dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata),
    .port_supply_switch_pad_i(pad_i), .port_supply_switch_pad_o(pad_o),
    .port_supply_switch_pad_oe(pad_oe), .supply_pad_pulldown_bits(pd),
    .supply_pad_pullup_bits(pu), .status_indicator_pin_pullup(led_pu),
    .usb2_power(src[0]), .usb3_power(src[1]), .gpio_power(src[2]), .port1_power_on(pwr_on),
    .port1_shared_pin(shared), .port1_disabled(dis), .fixed_attach_flag(fixed));
  supply_switch_model i_sw (.clk(clk), .pad_o(pad_o), .pad_oe(pad_oe), .pu(pu), .pd(pd),
    .ext_drv(ext_drv), .ext_en(ext_en), .pad_i(pad_i));
  // Compare and count
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      $display("[ERR] %s exp %h got %h", nm, e, g);
      miscompares++;
    end
  endtask
  // One-cycle strobes, launched just after an edge
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rc(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk($sformatf("rd %h", a), e, rdata);
  endtask
  // Reset seen at one edge; each port 1 select load after the register rows follows a fresh reset
  task automatic rst_pulse;
    @(posedge clk);
    sys_rst <= 1'b1;
    @(posedge clk);
    sys_rst <= 1'b0;
  endtask
  // Expected port 1 power for a code and source set
  function automatic logic pw(input logic [3:0] c, input logic [2:0] s);
    case (c)
      4'h1: return s[0];
      4'h2: return s[1];
      4'h3: return s[0] | s[1];
      4'h4: return s[2];
      default: return 1'b0;
    endcase
  endfunction
  // Expected input register with pull-ups on every pad
  function automatic logic [7:0] ine(input logic [7:0] o, input logic [7:0] d);
    return ((o & d) | (~d & ext_en & ext_drv) | (~d & ~ext_en)) & 8'hfe;
  endfunction
  task automatic final_report;
    $display("tests %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    foreach (rows[i]) begin
      rc(rows[i].a, 8'h00);
      wr(rows[i].a, rows[i].w);
      rc(rows[i].a, rows[i].r);
    end
    chk("led_pu", 8'h01, {7'h0, led_pu});
    chk("pd", 8'hfe, pd);
    chk("oe", 8'h06, pad_oe);
    chk("pad_o", 8'h02, pad_o);
    chk("pu", 8'hfe, pu);
    chk("flags", 8'h07, {5'h0, shared, dis, fixed});
    // Read-only input register ignores writes
    wr(pad_ctrl_pkg::PWR_IN_OFS, 8'h00);
    rc(pad_ctrl_pkg::PWR_IN_OFS, ine(8'h03, 8'h06));
    wr(pad_ctrl_pkg::PWR_DIR_OFS, 8'h00);
    rc(pad_ctrl_pkg::PWR_IN_OFS, ine(8'h03, 8'h00));
    chk("oe", 8'h00, pad_oe);
    // Select codes 0 to 7 against every source set
    for (int c = 0; c < 8; c++) begin
      rst_pulse;
      wr(pad_ctrl_pkg::SEL1_OFS, {4'h0, c[3:0]});
      for (int s = 0; s < 8; s++) begin
        @(posedge clk);
        src <= s[2:0];
        #1 chk("power", {7'h0, pw(c[3:0], s[2:0])}, {7'h0, pwr_on});
      end
    end
    rst_pulse;
    wr(pad_ctrl_pkg::SEL1_OFS, 8'h23);
    chk("power", 8'h00, {7'h0, pwr_on});
    chk("flags", 8'h02, {5'h0, shared, dis, fixed});
    // Shared and fixed flags apart from the disable flag
    rst_pulse;
    wr(pad_ctrl_pkg::SEL1_OFS, 8'h90);
    chk("flags", 8'h05, {5'h0, shared, dis, fixed});
    chk("power", 8'h00, {7'h0, pwr_on});
    // Write then read with no idle cycle between the strobes
    @(posedge clk);
    reg_addr <= pad_ctrl_pkg::PWR_OUT_OFS;
    reg_wdata <= 8'h0b;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk("b2b rd", 8'h0b, rdata);
    chk("pad_o", 8'h0a, pad_o);
    // Reset in mid-run clears every pad control and flag
    wr(pad_ctrl_pkg::PWR_PU_OFS, 8'hff);
    wr(pad_ctrl_pkg::PWR_PD_OFS, 8'hff);
    wr(pad_ctrl_pkg::LED_PU_OFS, 8'h01);
    wr(pad_ctrl_pkg::PWR_DIR_OFS, 8'hff);
    rst_pulse;
    #1 chk("pu", 8'h00, pu | pd | {7'h0, led_pu});
    chk("oe", 8'h00, pad_oe | pad_o);
    chk("flags", 8'h00, {5'h0, shared, dis, fixed});
    rc(pad_ctrl_pkg::PWR_DIR_OFS, 8'h00);
    final_report;
  end
  // Cuts a hang short
  initial begin
    #100000;
    miscompares++;
    final_report;
  end
endmodule
`default_nettype wire
